// *** aqc_pkg.sv ***
// package: register map, field layout and timing constants of the acquisition control block
// Overview of operation
// R1 - control register at 0x18 is write-only; a channel write switches the mux at once
// R2 - control bit 3 set selects external trigger; internal sources are then ignored
// R3 - control bit 2 picks timer pacer (1) or software trigger (0) when internal
// R4 - control bit 1 enables interrupt-driven transfer of converted data
// R5 - control bit 0 enables bus-master transfer of converted data
// R6 - software never enables interrupt and bus-master transfer together
// R7 - auto-scan off: every conversion uses the programmed channel only
// R8 - auto-scan on: channel steps down to 0, then wraps to programmed channel
// R9 - control bits 8..5 hold the channel number in plain binary, 0 to 15
// R10 - software uses channels 0..15 single-ended, 0..5 differential
// R11 - control bits 12..9 select bipolar ranges, codes 1000 and 0000..0011
// R12 - same field codes 0100..0111 select the unipolar ranges
// R13 - status read at 0x18 shows data-ready in bit 0
// R14 - status bit 1 flags overrun, meaningful only for bus-master transfer
// R15 - any write to 0x20 gives one trigger pulse that starts a conversion
// R16 - 16 digital inputs read and 16 outputs written in low half of 0x1C
// R17 - timer counters at 0x0, 0x4, 0x8 read/write; control byte at 0xC write-only
// R18 - two timer counters cascade into the pacer; the third is for the user
// R19 - reading the low byte of the data register clears data-ready
// R20 - external mode starts a conversion on each rising trigger edge
// R21 - interrupt mode raises a request when converted data are ready
// R22 - data word carries the 12-bit sample and the 4-bit source channel
// R23 - after reset the control word is zero
// R24 - overrun sets when a sample lands before the last was taken; restart clears
package aqc_pkg;
    // register offsets
    localparam logic [7:0] OFS_CNT0 = 8'h00;
    localparam logic [7:0] OFS_CNT1 = 8'h04;
    localparam logic [7:0] OFS_CNT2 = 8'h08;
    localparam logic [7:0] OFS_TCTL = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h18;
    localparam logic [7:0] OFS_DIO = 8'h1C;
    localparam logic [7:0] OFS_STRG = 8'h20;
    // control word fields
    localparam int B_DMA = 0;
    localparam int B_IRQ = 1;
    localparam int B_KIND = 2;
    localparam int B_EXT = 3;
    localparam int B_SCAN = 4;
    localparam int CH_LO = 5;
    localparam int CH_HI = 8;
    localparam int RG_LO = 9;
    localparam int RG_HI = 12;
    localparam int CTRL_W = 13;
    localparam logic [12:0] CTRL_RST = 13'h0000;
    // status and data word fields
    localparam int ST_RDY = 0;
    localparam int ST_OVR = 1;
    localparam int DAT_SMP_LO = 4;
    localparam int SMP_W = 12;
    localparam int DIO_W = 16;
    // timer: counter count, width and base tick rate
    localparam int TMR_N = 3;
    localparam int TMR_W = 16;
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int TMR_CLK_HZ = 2_000_000;
    localparam int TMR_DIV = SYS_CLK_HZ / TMR_CLK_HZ;
    localparam int TSEL_LO = 6;
endpackage

// *** aqc_core_if.sv ***
// interface: signals between the top level and its timer and converter sequencer
`timescale 1ns/1ps
`default_nettype none
interface aqc_core_if;
    import aqc_pkg::*;
    logic tmr_wr;
    logic [1:0] tmr_sel;
    logic [TMR_W-1:0] tmr_wdata;
    logic tctl_wr;
    logic [TMR_N-1:0][TMR_W-1:0] tmr_cnt;
    logic pacer_p;
    logic tmr2_out;
    logic cnv_trig;
    logic cnv_restart;
    logic cnv_scan;
    logic [3:0] cnv_ch;
    logic eoc_s;
    logic [SMP_W-1:0] adc_q;
    logic smp_vld;
    logic [15:0] smp_word;
    logic [3:0] mux_ch;
    logic adc_start;
    logic busy;
    modport top (output tmr_wr, tmr_sel, tmr_wdata, tctl_wr, cnv_trig, cnv_restart,
        cnv_scan, cnv_ch, eoc_s, adc_q, input tmr_cnt, pacer_p, tmr2_out, smp_vld,
        smp_word, mux_ch, adc_start, busy);
    modport tmr (input tmr_wr, tmr_sel, tmr_wdata, tctl_wr, output tmr_cnt, pacer_p,
        tmr2_out);
    modport cnv (input cnv_trig, cnv_restart, cnv_scan, cnv_ch, eoc_s, adc_q,
        output smp_vld, smp_word, mux_ch, adc_start, busy);
endinterface
`default_nettype wire

// *** aqc_timer.sv ***
// three down-counters; counters 0 and 1 cascade into the conversion pacer
`timescale 1ns/1ps
`default_nettype none
module aqc_timer
    import aqc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // link to the top level
    aqc_core_if.tmr cif
);
    typedef struct packed {
        logic [4:0] div;
        logic [TMR_N-1:0][TMR_W-1:0] cnt;
        logic [TMR_N-1:0][TMR_W-1:0] rld;
        logic [TMR_N-1:0] out;
    } aqc_tmr_st_t;
    aqc_tmr_st_t st_r, st_nxt;
    logic tick;
    logic [TMR_N-1:0] step;
    logic [TMR_N-1:0] tc;

    // base tick enable from the system clock divider
    assign tick = (st_r.div == 5'(TMR_DIV - 1));
    // counter 1 steps on counter 0 terminal count: the cascade
    assign step = {tick, tc[0], tick}; // [R18]
    for (genvar i = 0; i < TMR_N; i++) begin : g_tc
        assign tc[i] = step[i] && (st_r.cnt[i] <= 16'h0001);
    end
    assign cif.pacer_p = tc[1]; // [R18]
    assign cif.tmr_cnt = st_r.cnt;
    assign cif.tmr2_out = st_r.out[2];

    // reload on terminal count; a count of zero ends at the next step, like a count of one
    always_comb begin
        st_nxt = st_r;
        st_nxt.div = tick ? 5'h00 : st_r.div + 5'h01;
        for (int i = 0; i < TMR_N; i++) begin
            if (tc[i]) begin
                st_nxt.cnt[i] = st_r.rld[i];
                st_nxt.out[i] = ~st_r.out[i];
            end else if (step[i]) begin
                st_nxt.cnt[i] = st_r.cnt[i] - 16'h0001;
            end
        end
        if (cif.tmr_wr) begin // [R17]
            st_nxt.rld[cif.tmr_sel] = cif.tmr_wdata;
            st_nxt.cnt[cif.tmr_sel] = cif.tmr_wdata;
        end
        if (cif.tctl_wr && cif.tmr_sel != 2'h3) begin // select 3 names no counter
            st_nxt.cnt[cif.tmr_sel] = st_r.rld[cif.tmr_sel]; // restart one counter
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    AST_PACER_CASCADE: assert property (cif.pacer_p |-> tc[0] && tick) // [R18]
        else $error("pacer pulse without counter 0 terminal count");
    AST_CNT1_HOLD: assert property (!tc[0] && !cif.tmr_wr && !cif.tctl_wr // [R18]
        |=> st_r.cnt[1] == $past(st_r.cnt[1]))
        else $error("counter 1 moved without a counter 0 terminal count");
endmodule
`default_nettype wire

// *** aqc_conv.sv ***
// conversion sequencer: start pulse, end-of-conversion capture and auto-scan stepping
`timescale 1ns/1ps
`default_nettype none
module aqc_conv
    import aqc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // link to the top level
    aqc_core_if.cnv cif
);
    typedef enum logic [2:0] {
        CV_IDLE = 3'b001,
        CV_START = 3'b010,
        CV_WAIT = 3'b100
    } aqc_cv_t;
    typedef struct packed {
        aqc_cv_t state;
        logic [3:0] cur_ch;
        logic eoc_d;
        logic vld;
        logic [15:0] word;
    } aqc_cv_st_t;
    aqc_cv_st_t st_r, st_nxt;
    logic eoc_rise;

    assign eoc_rise = cif.eoc_s && !st_r.eoc_d;
    assign cif.adc_start = (st_r.state == CV_START);
    assign cif.busy = (st_r.state != CV_IDLE);
    assign cif.mux_ch = st_r.cur_ch;
    assign cif.smp_vld = st_r.vld;
    assign cif.smp_word = st_r.word;

    // triggers while busy are dropped; a control write aborts and reloads the channel
    always_comb begin
        st_nxt = st_r;
        st_nxt.eoc_d = cif.eoc_s;
        st_nxt.vld = 1'b0;
        case (st_r.state)
            CV_IDLE: begin
                if (cif.cnv_trig) begin
                    st_nxt.state = CV_START;
                end
            end
            CV_START: st_nxt.state = CV_WAIT;
            CV_WAIT: begin
                if (eoc_rise) begin
                    st_nxt.state = CV_IDLE;
                    st_nxt.vld = 1'b1;
                    st_nxt.word = {cif.adc_q, st_r.cur_ch}; // [R22]
                    if (!cif.cnv_scan) begin
                        st_nxt.cur_ch = cif.cnv_ch; // [R7]
                    end else if (st_r.cur_ch == 4'h0) begin
                        st_nxt.cur_ch = cif.cnv_ch; // [R8]
                    end else begin
                        st_nxt.cur_ch = st_r.cur_ch - 4'h1; // [R8]
                    end
                end
            end
            default: st_nxt.state = CV_IDLE;
        endcase
        if (cif.cnv_restart) begin
            st_nxt.state = CV_IDLE;
            st_nxt.cur_ch = cif.cnv_ch; // [R1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '{state: CV_IDLE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_done_scan;
        st_r.state == CV_WAIT && eoc_rise && cif.cnv_scan && !cif.cnv_restart;
    endsequence
    AST_SCAN_WRAP: assert property (s_done_scan ##0 st_r.cur_ch == 4'h0 // [R8]
        |=> st_r.cur_ch == $past(cif.cnv_ch))
        else $error("auto-scan did not wrap to the programmed channel");
    AST_SCAN_STEP: assert property (s_done_scan ##0 st_r.cur_ch != 4'h0 // [R8]
        |=> st_r.cur_ch == $past(st_r.cur_ch) - 4'h1)
        else $error("auto-scan did not step down by one");
    AST_NO_SCAN: assert property (cif.smp_vld && !cif.cnv_scan && !cif.cnv_restart // [R7]
        |-> st_r.cur_ch == cif.cnv_ch)
        else $error("channel moved with auto-scan off");
endmodule
`default_nettype wire

// *** aqc_top.sv ***
// acquisition control: i/o register port, trigger selection, status flags and digital i/o
`timescale 1ns/1ps
`default_nettype none
module aqc_top
    import aqc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // target i/o register port
    input wire logic [7:0] io_addr,
    input wire logic [3:0] io_be,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [31:0] io_wdata,
    output logic [31:0] io_rdata,
    // converter and front end
    output logic adc_start,
    output logic [3:0] adc_mux_ch,
    output logic [3:0] adc_range,
    output logic adc_unipolar,
    input wire logic adc_eoc,
    input wire logic [SMP_W-1:0] adc_data,
    input wire logic external_trigger_input,
    // transfer paths
    output logic irq,
    output logic dma_req,
    input wire logic dma_ack,
    // digital i/o and user counter
    input wire logic [DIO_W-1:0] dig_in,
    output logic [DIO_W-1:0] dig_out,
    output logic tmr2_out
);
    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [DIO_W-1:0] dout;
        logic [15:0] data;
        logic sample_ready_flag;
        logic sample_overrun_flag;
        logic smp_pend;
        logic [31:0] rdata;
        logic [2:0] ext_s;
        logic [1:0] eoc_s;
        logic [SMP_W-1:0] adq_s1;
        logic [SMP_W-1:0] adq_s2;
        logic [DIO_W-1:0] di_s1;
        logic [DIO_W-1:0] di_s2;
    } aqc_top_st_t;
    aqc_top_st_t st_r, st_nxt;
    aqc_core_if cif ();

    logic ext_int_trigger_select;
    logic pacer_or_soft_trigger_select;
    logic irq_transfer_enable;
    logic busmaster_transfer_enable;
    logic auto_scan;
    logic [3:0] channel_select_field;
    logic range_code_msb;
    logic ctrl_wr;
    logic soft_wr;
    logic data_lo_rd;
    logic ext_rise;
    logic [31:0] rd_mux;

    // control word fields
    assign ext_int_trigger_select = st_r.ctrl[B_EXT];
    assign pacer_or_soft_trigger_select = st_r.ctrl[B_KIND];
    assign irq_transfer_enable = st_r.ctrl[B_IRQ];
    assign busmaster_transfer_enable = st_r.ctrl[B_DMA];
    assign auto_scan = st_r.ctrl[B_SCAN];
    assign channel_select_field = st_r.ctrl[CH_HI:CH_LO]; // [R9]
    assign range_code_msb = st_r.ctrl[RG_HI];

    // address decode of the write and read strobes
    assign ctrl_wr = io_wr && (io_addr == OFS_CTRL);
    assign soft_wr = io_wr && (io_addr == OFS_STRG); // [R15]
    assign data_lo_rd = io_rd && (io_addr == OFS_DATA) && io_be[0]; // [R19]
    // edge seen on the second and third synchroniser stages only
    assign ext_rise = st_r.ext_s[1] && !st_r.ext_s[2]; // [R20]

    // timer access shares the low four words of the map
    assign cif.tmr_wr = io_wr && (io_addr == OFS_CNT0 || io_addr == OFS_CNT1 ||
        io_addr == OFS_CNT2); // [R17]
    assign cif.tmr_sel = cif.tctl_wr ? io_wdata[TSEL_LO+1:TSEL_LO] : io_addr[3:2];
    assign cif.tmr_wdata = io_wdata[TMR_W-1:0];
    assign cif.tctl_wr = io_wr && (io_addr == OFS_TCTL); // [R17]

    // trigger source select: external edge masks both internal sources
    always_comb begin
        if (ext_int_trigger_select) begin
            cif.cnv_trig = ext_rise; // [R2]
        end else if (pacer_or_soft_trigger_select) begin
            cif.cnv_trig = cif.pacer_p; // [R3]
        end else begin
            cif.cnv_trig = soft_wr; // [R3]
        end
    end
    assign cif.cnv_restart = ctrl_wr; // [R1]
    assign cif.cnv_scan = auto_scan;
    // a control write hands its new channel over in the same cycle, so the mux moves at once
    assign cif.cnv_ch = ctrl_wr ? io_wdata[CH_HI:CH_LO] : channel_select_field; // [R1]
    assign cif.eoc_s = st_r.eoc_s[1];
    assign cif.adc_q = st_r.adq_s2;

    aqc_timer u_timer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cif(cif)
    );

    aqc_conv u_conv (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .cif(cif)
    );

    // read multiplexer; unmapped and write-only offsets read as zero
    always_comb begin
        case (io_addr)
            OFS_CNT0: rd_mux = {16'h0000, cif.tmr_cnt[0]}; // [R17]
            OFS_CNT1: rd_mux = {16'h0000, cif.tmr_cnt[1]};
            OFS_CNT2: rd_mux = {16'h0000, cif.tmr_cnt[2]};
            OFS_DATA: rd_mux = {16'h0000, st_r.data}; // [R22]
            OFS_CTRL: rd_mux = {30'h00000000, st_r.sample_overrun_flag,
                st_r.sample_ready_flag}; // [R13] [R14]
            OFS_DIO: rd_mux = {16'h0000, st_r.di_s2}; // [R16]
            default: rd_mux = 32'h00000000;
        endcase
    end

    // next state: register writes, flag set/clear, synchronisers
    always_comb begin
        st_nxt = st_r;
        st_nxt.ext_s = {st_r.ext_s[1:0], external_trigger_input};
        st_nxt.eoc_s = {st_r.eoc_s[0], adc_eoc};
        st_nxt.adq_s1 = adc_data;
        st_nxt.adq_s2 = st_r.adq_s1;
        st_nxt.di_s1 = dig_in;
        st_nxt.di_s2 = st_r.di_s1;
        if (io_rd) begin
            st_nxt.rdata = rd_mux;
        end
        if (ctrl_wr) begin
            st_nxt.ctrl = io_wdata[CTRL_W-1:0]; // [R1] [R11] [R12]
        end
        if (io_wr && (io_addr == OFS_DIO)) begin
            st_nxt.dout = io_wdata[DIO_W-1:0]; // [R16]
        end
        if (cif.smp_vld) begin
            st_nxt.data = cif.smp_word; // [R22]
        end
        // ready drops while converting and once consumed; a new sample wins
        if (cif.adc_start || data_lo_rd || dma_ack) begin
            st_nxt.sample_ready_flag = 1'b0; // [R19]
        end
        // pending survives a new start, so an untaken sample is still known at the next end
        if (data_lo_rd || dma_ack || ctrl_wr) begin
            st_nxt.smp_pend = 1'b0;
        end
        if (cif.smp_vld) begin
            st_nxt.sample_ready_flag = 1'b1; // [R13]
            st_nxt.smp_pend = 1'b1;
        end
        // overrun holds until the acquisition is reprogrammed
        if (ctrl_wr) begin
            st_nxt.sample_overrun_flag = 1'b0; // [R24]
        end
        if (cif.smp_vld && st_r.smp_pend && !dma_ack &&
            busmaster_transfer_enable) begin
            st_nxt.sample_overrun_flag = 1'b1; // [R14] [R24]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '{ctrl: CTRL_RST, default: '0}; // [R23]
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs; only one transfer enable is expected to be set at a time
    assign io_rdata = st_r.rdata;
    assign adc_start = cif.adc_start;
    assign adc_mux_ch = cif.mux_ch; // [R1]
    assign adc_range = st_r.ctrl[RG_HI:RG_LO]; // [R11] [R12]
    assign adc_unipolar = !range_code_msb && st_r.ctrl[RG_LO+2]; // [R12]
    assign irq = st_r.sample_ready_flag && irq_transfer_enable; // [R4] [R21]
    assign dma_req = st_r.sample_ready_flag && busmaster_transfer_enable; // [R5]
    assign dig_out = st_r.dout;
    assign tmr2_out = cif.tmr2_out;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_idle_soft;
        soft_wr && !ext_int_trigger_select && !pacer_or_soft_trigger_select &&
            !cif.busy && !ctrl_wr;
    endsequence
    sequence s_start_pulse;
        adc_start ##1 !adc_start;
    endsequence
    AST_SOFT_TRIG: assert property (s_idle_soft |=> s_start_pulse) // [R15]
        else $error("software trigger did not give one start pulse");
    AST_EXT_MASKS: assert property (ext_int_trigger_select && !ext_rise && !cif.busy // [R2]
        && !ctrl_wr |=> !adc_start)
        else $error("start issued without an external edge in external mode");
    AST_EXT_EDGE: assert property (ext_rise && ext_int_trigger_select && !cif.busy // [R20]
        && !ctrl_wr |=> adc_start)
        else $error("external rising edge did not start a conversion");
    AST_RDY_SET: assert property (cif.smp_vld |=> st_r.sample_ready_flag) // [R13]
        else $error("ready flag not set after a sample");
    AST_RDY_CLR: assert property (data_lo_rd && !cif.smp_vld // [R19]
        |=> !st_r.sample_ready_flag)
        else $error("ready flag not cleared by data low byte read");
    AST_IRQ: assert property (cif.smp_vld && irq_transfer_enable && !ctrl_wr // [R21]
        |=> irq ##1 (irq || $past(cif.adc_start || data_lo_rd || dma_ack || ctrl_wr)))
        else $error("interrupt request missing after a sample");
    AST_DMA_REQ: assert property (cif.smp_vld && busmaster_transfer_enable // [R5]
        && !ctrl_wr |=> dma_req)
        else $error("bus-master request missing after a sample");
    AST_OVR_HOLD: assert property (st_r.sample_overrun_flag && !ctrl_wr // [R24]
        |=> st_r.sample_overrun_flag)
        else $error("overrun flag dropped without a restart");
    AST_MUX_WR: assert property (ctrl_wr |=> adc_mux_ch == $past(io_wdata[8:5]) // [R1]
        && adc_range == $past(io_wdata[12:9]))
        else $error("control write did not reach mux or range");
    AST_DOUT: assert property (io_wr && io_addr == OFS_DIO // [R16]
        |=> dig_out == $past(io_wdata[15:0]))
        else $error("digital output not latched");
endmodule
`default_nettype wire

// *** aqc_adc_model.sv ***
// converter front-end model: answers each start pulse with a sample tagged by its channel
`timescale 1ns/1ps
`default_nettype none
module aqc_adc_model #(
    parameter int CONV_CYC = 10
) (
    // clock
    input wire logic sys_clk,
    // converter handshake
    input wire logic adc_start,
    input wire logic [3:0] adc_mux_ch,
    output logic adc_eoc,
    output logic [11:0] adc_data
);
    int cnt = 0;
    logic [3:0] ch_r = 4'h0;
    initial begin
        adc_eoc = 1'b0;
        adc_data = 12'h000;
    end
    // data flips to its inverse while converting, so a capture taken too early shows up
    always @(posedge sys_clk) begin
        if (adc_start === 1'b1) begin
            ch_r <= adc_mux_ch;
            adc_data <= ~adc_data;
            cnt <= CONV_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 4) adc_data <= {ch_r, 8'hA5};
            if (cnt == 3) adc_eoc <= 1'b1;
            if (cnt == 1) adc_eoc <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** tb_adc_acquisition_control_regs.sv ***
// self-checking bench for the acquisition control block with a converter model
`timescale 1ns/1ps
`default_nettype none
module tb_adc_acquisition_control_regs;
    import aqc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [3:0] io_be = 4'h0;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [31:0] io_wdata = 32'h0;
    logic [31:0] io_rdata, rd_v;
    logic adc_start, adc_eoc, adc_unipolar, irq, dma_req, tmr2_out;
    logic [3:0] adc_mux_ch, adc_range;
    logic [SMP_W-1:0] adc_data;
    logic ext_trig = 1'b0;
    logic dma_ack = 1'b0;
    logic [DIO_W-1:0] dig_in = 16'h0000;
    logic [DIO_W-1:0] dig_out;
    int n_errors = 0;
    int check_count = 0;
    int n_start = 0;
    // 40 MHz system clock
    always #12.5 sys_clk = ~sys_clk;
    // start pulses counted so dropped or doubled triggers show
    always @(posedge sys_clk) if (adc_start === 1'b1) n_start <= n_start + 1;
    aqc_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr), .io_be(io_be),
        .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .adc_start(adc_start), .adc_mux_ch(adc_mux_ch), .adc_range(adc_range),
        .adc_unipolar(adc_unipolar), .adc_eoc(adc_eoc), .adc_data(adc_data),
        .external_trigger_input(ext_trig), .irq(irq), .dma_req(dma_req),
        .dma_ack(dma_ack), .dig_in(dig_in), .dig_out(dig_out), .tmr2_out(tmr2_out));
    aqc_adc_model adc_u (.sys_clk(sys_clk), .adc_start(adc_start),
        .adc_mux_ch(adc_mux_ch), .adc_eoc(adc_eoc), .adc_data(adc_data));
    // single compare point
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // register write, strobe held for exactly one edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge sys_clk);
        io_wr <= 1'b0;
    endtask
    // register read; data is registered on the taking edge
    task automatic rd(input logic [7:0] a, input logic [3:0] be);
        @(posedge sys_clk);
        io_addr <= a;
        io_be <= be;
        io_rd <= 1'b1;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        #1;
        rd_v = io_rdata;
    endtask
    // bounded poll of the ready flag
    task automatic wait_ready();
        for (int i = 0; i < 100; i++) begin
            rd(OFS_CTRL, 4'h1);
            if (rd_v[ST_RDY] === 1'b1) return;
        end
        chk(32'h0, 32'h1);
        summarize();
    endtask
    // bounded wait on irq (0) or bus-master request (1)
    task automatic wait_out(input int sel);
        for (int i = 0; i < 3000; i++) begin
            @(posedge sys_clk);
            #1;
            if (sel == 0 && irq === 1'b1) return;
            if (sel == 1 && dma_req === 1'b1) return;
        end
        chk(32'h0, 32'h1);
        summarize();
    endtask
    // one external trigger pulse, long enough to pass the input synchronizer
    task automatic ext_pulse();
        @(posedge sys_clk);
        ext_trig <= 1'b1;
        repeat (4) @(posedge sys_clk);
        ext_trig <= 1'b0;
    endtask
    // one software-started conversion, read back against the channel it used
    task automatic soft_conv(input logic [3:0] ch);
        int s;
        s = n_start;
        wr(OFS_STRG, 32'hDEAD_BEEF);
        wait_ready();
        chk(32'(n_start - s), 32'h1);
        rd(OFS_DATA, 4'h1);
        chk(rd_v, {16'h0000, ch, 8'hA5, ch});
        rd(OFS_CTRL, 4'h1);
        chk(rd_v, 32'h0);
    endtask
    // reset state and reads of write-only or unmapped places
    task automatic t_reset();
        rd(OFS_CTRL, 4'h1);
        chk(rd_v, 32'h0);
        chk(32'({adc_range, adc_unipolar, adc_mux_ch}), 32'h0);
        rd(8'h24, 4'hF);
        chk(rd_v, 32'h0);
        rd(OFS_TCTL, 4'hF);
        chk(rd_v, 32'h0);
    endtask
    // every range code with a channel that moves the mux at once
    task automatic t_fields();
        logic [3:0] ch;
        for (int code = 0; code < 9; code++) begin
            ch = 4'(15 - code);
            wr(OFS_CTRL, (32'(code) << 9) | (32'(ch) << 5));
            #1;
            chk(32'(adc_mux_ch), 32'(ch));
            chk(32'({adc_range, adc_unipolar}), {27'h0, 4'(code), 1'(code / 4 == 1)});
        end
    endtask
    // fixed channel, then downward scan with wrap
    task automatic t_scan();
        wr(OFS_CTRL, 32'h0000_0060);
        soft_conv(4'h3);
        soft_conv(4'h3);
        wr(OFS_CTRL, 32'h0000_0050);
        for (int i = 0; i < 4; i++) soft_conv(4'(2 - i % 3));
    endtask
    // external source shuts out both internal ones; one start per rising edge
    task automatic t_ext();
        int s;
        wr(OFS_CTRL, 32'h0000_000C);
        s = n_start;
        wr(OFS_STRG, 32'h0000_0001);
        repeat (300) @(posedge sys_clk);
        chk(32'(n_start - s), 32'h0);
        ext_pulse();
        wait_ready();
        chk(32'(n_start - s), 32'h1);
        rd(OFS_DATA, 4'h1);
        chk(rd_v, 32'h0000_0A50);
    endtask
    // pacer ignored in software mode, then paces with interrupt transfer
    task automatic t_pacer();
        int s;
        wr(OFS_CNT0, 32'h2);
        wr(OFS_CNT1, 32'h3);
        wr(OFS_CTRL, 32'h0);
        s = n_start;
        repeat (400) @(posedge sys_clk);
        chk(32'(n_start - s), 32'h0);
        wr(OFS_CTRL, 32'h0000_0006);
        wait_out(0);
        chk(32'(dma_req), 32'h0);
        rd(OFS_DATA, 4'h1);
        chk(32'(irq), 32'h0);
        wait_out(0);
        wr(OFS_CTRL, 32'h0);
        repeat (40) @(posedge sys_clk);
        rd(OFS_DATA, 4'h1);
    endtask
    // bus-master request, overrun, acknowledge and restart
    task automatic t_dma();
        wr(OFS_CTRL, 32'h0000_0009);
        ext_pulse();
        wait_out(1);
        chk(32'(irq), 32'h0);
        ext_pulse();
        repeat (40) @(posedge sys_clk);
        rd(OFS_CTRL, 4'h1);
        chk(rd_v, 32'h3);
        @(posedge sys_clk);
        dma_ack <= 1'b1;
        @(posedge sys_clk);
        dma_ack <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(32'(dma_req), 32'h0);
        rd(OFS_CTRL, 4'h1);
        chk(rd_v, 32'h2);
        wr(OFS_CTRL, 32'h0000_0009);
        rd(OFS_CTRL, 4'h1);
        chk(rd_v, 32'h0);
    endtask
    // digital ports and a running user counter
    task automatic t_dio_tmr();
        logic [31:0] v1;
        @(posedge sys_clk);
        dig_in <= 16'h5AC3;
        repeat (4) @(posedge sys_clk);
        rd(OFS_DIO, 4'hF);
        chk(rd_v, 32'h0000_5AC3);
        wr(OFS_DIO, 32'hFFFF_3C96);
        #1;
        chk(32'(dig_out), 32'h0000_3C96);
        wr(OFS_CNT2, 32'h40);
        rd(OFS_CNT2, 4'hF);
        v1 = rd_v;
        chk(32'(v1 <= 32'h40 && v1 != 0), 32'h1);
        repeat (100) @(posedge sys_clk);
        rd(OFS_CNT2, 4'hF);
        chk(32'(rd_v != v1), 32'h1);
        // control byte selecting counter 2 restarts it from its reload value
        wr(OFS_TCTL, 32'h0000_0080);
        rd(OFS_CNT2, 4'hF);
        chk(32'(rd_v == 32'h40 || rd_v == 32'h3F), 32'h1);
        // reload of 2 toggles the user output every two base ticks, 40 clocks
        wr(OFS_CNT2, 32'h2);
        #1;
        v1 = 32'(tmr2_out);
        repeat (40) @(posedge sys_clk);
        #1;
        chk(32'(tmr2_out), ~v1 & 32'h1);
    endtask
    // main sequence: reset held six cycles, then every scenario
    initial begin
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_fields();
        t_scan();
        t_ext();
        t_pacer();
        t_dma();
        t_dio_tmr();
        summarize();
    end
endmodule
`default_nettype wire
